// file: mrwd_host_model.sv
// Purpose: Host model: acks reply bytes, judges commits
// Assumes: Ack is a one-cycle pulse after a shown byte
// Notes: One value is refused to provoke an exception
`timescale 1ns/1ps
module mrwd_host_model #(
	parameter logic [15:0] bad_val = 16'hDEAD // Refused value
) (
	input wire logic i_core_clk,
	input wire logic i_nrst,
	input wire logic i_slow,
	input wire logic i_wr_valid,
	input wire mrwd_pkg::mrwd_wr_t i_wr,
	input wire logic i_tx_valid,
	output mrwd_pkg::mrwd_chk_t o_wr_chk,
	output logic o_tx_ready
);
	logic [1:0] gap_q; // Cycles before next ack
	// Refused-value verdict in the commit cycle
	assign o_wr_chk.reject = i_wr_valid && i_wr.data == bad_val;
	// Ack each shown byte, promptly or late
	always_ff @(posedge i_core_clk) begin
		if (!i_nrst || o_tx_ready) begin
			o_tx_ready <= 1'b0;
			gap_q <= i_slow ? 2'h3 : 2'h0;
		end else if (gap_q != 2'h0) begin
			gap_q <= gap_q - 2'h1;
		end else begin
			o_tx_ready <= i_tx_valid;
		end
	end
endmodule // mrwd_host_model

// file: mrwd_params.svh
// Purpose: Constants for the serial register-write and diagnosis slave
// Assumes: One 100 MHz clock, frames delivered as a byte stream with end marker
// Notes: Definitions only
`ifndef MRWD_PARAMS_SVH
`define MRWD_PARAMS_SVH
`define MRWD_FC_WRITE_ONE 8'h06
`define MRWD_FC_DIAG 8'h08
`define MRWD_FC_WRITE_MANY 8'h10
`define MRWD_SUB_ECHO 16'h0000
`define MRWD_EXC_FUNC 8'h01
`define MRWD_EXC_ADDR 8'h02
`define MRWD_EXC_DATA 8'h03
`define MRWD_EXC_FLAG 8'h80
`define MRWD_ADDR_LIMIT 17'h02000
`define MRWD_MAX_REGS 16'h0010
`define MRWD_CRC_INIT 16'hFFFF
`define MRWD_CRC_POLY 16'hA001
`define MRWD_BUF_DEPTH 41
`define MRWD_HDR_MANY 7
`endif

// file: mrwd_pkg.sv
// Purpose: Types for the serial register-write and diagnosis slave
// Assumes: Constants come from mrwd_params.svh
// Notes: Types only
package mrwd_pkg;
	// Register commit toward the register store
	typedef struct packed {
		logic [15:0] addr;
		logic [15:0] data;
	} mrwd_wr_t;
	// Checker verdict on a value offered for commit
	typedef struct packed {
		logic reject;
	} mrwd_chk_t;
endpackage

// file: mrwd_slave.sv
// Purpose: Executes write-one, diagnosis and write-many frames and builds replies
// Assumes: Receive bytes come framed by a last flag from a character layer
// Notes: Reply bytes leave on a valid/ready stream, CRC appended here
`timescale 1ns/1ps
`include "mrwd_params.svh"
// Contract
// R1: Write-one stores value, echoes whole query
// R2: Master pairs 32-bit halves in write-many
// R3: Diagnosis echoes sub-function and data unchanged
// R4: Only echo sub-function executes
// R5: Write-many accepts up to sixteen registers
// R6: Write-many reply repeats header, no data
// R7: Byte count must be twice register count
// R8: Commit registers one at a time ascending
// R9: Rejected value keeps earlier commits
// R10: Master never splits 32-bit updates
// R11: CRC-16 low byte first, checked
// R12: Address outside range gives exception two
// R13: Bad count or byte count gives three
// R14: Unknown function or sub-function gives one
// R15: Even address upper half, odd lower
// R16: Exception reply sets function top bit
// R17: Bad CRC or address dropped silently
module mrwd_slave (
	input wire logic i_core_clk,
	input wire logic i_nrst,
	input wire logic [7:0] i_own_addr,
	input wire logic i_rx_valid,
	input wire logic [7:0] i_rx_data,
	input wire logic i_rx_last,
	output logic o_wr_valid,
	output mrwd_pkg::mrwd_wr_t o_wr,
	output logic o_wr_half_lo,
	input wire mrwd_pkg::mrwd_chk_t i_wr_chk,
	output logic o_tx_valid,
	output logic [7:0] o_tx_data,
	output logic o_tx_last,
	input wire logic i_tx_ready
);
	typedef enum logic [2:0] {ST_RX, ST_CHECK, ST_COMMIT, ST_REPLY, ST_CRC_LO, ST_CRC_HI} mrwd_state_t;

	// ************************************************************
	// CRC helper
	// ************************************************************
	// One byte into a reflected CRC-16
	function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {8'h00, b};
		for (int k = 0; k < 8; k++) begin
			r = r[0] ? ((r >> 1) ^ `MRWD_CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	// ************************************************************
	// Storage
	// ************************************************************
	logic [7:0] buf_q [`MRWD_BUF_DEPTH]; // Received frame bytes, reused for reply
	logic [5:0] len_q; // Received byte count
	logic ovf_q; // Frame longer than buffer
	logic [15:0] rcrc_q; // Running receive CRC
	logic [15:0] rprev2_q; // CRC over all but the newest byte
	logic [7:0] last0_q; // Newest byte, CRC low byte at frame end
	mrwd_state_t st_q; // Control state
	logic [5:0] tx_idx_q; // Reply byte index
	logic [5:0] tx_len_q; // Reply length before CRC
	logic [15:0] tcrc_q; // Running transmit CRC
	logic [4:0] cnt_q; // Registers committed so far
	logic [7:0] exc_q; // Pending exception code
	logic [15:0] base_w; // Start address field
	logic [15:0] num_w; // Count or value field
	logic [16:0] end_w; // Start plus count

	assign base_w = {buf_q[2], buf_q[3]};
	assign num_w = {buf_q[4], buf_q[5]};
	assign end_w = {1'b0, base_w} + {1'b0, num_w};

	// ************************************************************
	// Receive capture
	// ************************************************************
	// Store bytes, keep CRC history of last two bytes
	always_ff @(posedge i_core_clk) begin
		if (!i_nrst) begin
			len_q <= 6'h00;
			ovf_q <= 1'b0;
			rcrc_q <= `MRWD_CRC_INIT;
			rprev2_q <= `MRWD_CRC_INIT;
			last0_q <= 8'h00;
		end else if (st_q == ST_RX && i_rx_valid) begin
			if (len_q < 6'(`MRWD_BUF_DEPTH)) begin
				buf_q[len_q] <= i_rx_data;
			end else begin
				ovf_q <= 1'b1; // Too long, dropped later
			end
			rcrc_q <= crc_step(rcrc_q, i_rx_data);
			rprev2_q <= rcrc_q;
			last0_q <= i_rx_data;
			len_q <= (len_q == 6'h3F) ? len_q : len_q + 6'h01;
			if (i_rx_last) begin
				len_q <= 6'h00;
				ovf_q <= 1'b0;
				rcrc_q <= `MRWD_CRC_INIT;
				rprev2_q <= `MRWD_CRC_INIT;
			end
		end else if (st_q == ST_REPLY && o_tx_valid && i_tx_ready) begin
			// Nothing captured while replying
			len_q <= 6'h00;
		end
	end

	// ************************************************************
	// Frame snapshot taken at the last byte
	// ************************************************************
	logic [5:0] flen_q; // Frame length incl. CRC
	logic fok_q; // CRC good and frame fits buffer
	always_ff @(posedge i_core_clk) begin
		if (!i_nrst) begin
			flen_q <= 6'h00;
			fok_q <= 1'b0;
		end else if (st_q == ST_RX && i_rx_valid && i_rx_last) begin
			flen_q <= len_q + 6'h01;
			// CRC over the data bytes, sent low byte first (see R11)
			fok_q <= !ovf_q && (len_q >= 6'h03) && (rprev2_q == {i_rx_data, last0_q});
		end
	end

	// ************************************************************
	// Control
	// ************************************************************
	// Validate, commit, then reply
	always_ff @(posedge i_core_clk) begin
		if (!i_nrst) begin
			st_q <= ST_RX;
			cnt_q <= 5'h00;
			exc_q <= 8'h00;
			tx_len_q <= 6'h00;
		end else begin
			unique case (st_q)
				ST_RX: begin
					if (i_rx_valid && i_rx_last) begin
						st_q <= ST_CHECK;
					end
				end
				ST_CHECK: begin
					exc_q <= 8'h00;
					cnt_q <= 5'h00;
					if (!fok_q || buf_q[0] != i_own_addr) begin
						st_q <= ST_RX; // Silent drop (see R17)
					end else if (buf_q[1] == `MRWD_FC_WRITE_ONE && flen_q == 6'd8) begin
						if (base_w > 16'(`MRWD_ADDR_LIMIT - 17'h1)) begin
							exc_q <= `MRWD_EXC_ADDR; // see R12
							st_q <= ST_REPLY;
						end else begin
							st_q <= ST_COMMIT;
						end
						tx_len_q <= 6'd6; // Whole query echoed (see R1)
					end else if (buf_q[1] == `MRWD_FC_DIAG && flen_q == 6'd8) begin
						if (base_w != `MRWD_SUB_ECHO) begin
							exc_q <= `MRWD_EXC_FUNC; // see R4, R14
						end
						tx_len_q <= 6'd6; // Echo sub-function and data (see R3)
						st_q <= ST_REPLY;
					end else if (buf_q[1] == `MRWD_FC_WRITE_MANY && flen_q >= 6'd9) begin
						tx_len_q <= 6'd6; // Header only reply (see R6)
						if (num_w == 16'h0000 || num_w > `MRWD_MAX_REGS ||
							{8'h00, buf_q[6]} != {num_w[14:0], 1'b0} ||
							flen_q != 6'(`MRWD_HDR_MANY + 2) + buf_q[6][5:0]) begin
							exc_q <= `MRWD_EXC_DATA; // see R5, R7, R13
							st_q <= ST_REPLY;
						end else if (end_w >= `MRWD_ADDR_LIMIT) begin
							exc_q <= `MRWD_EXC_ADDR; // see R12
							st_q <= ST_REPLY;
						end else begin
							st_q <= ST_COMMIT;
						end
					end else begin
						exc_q <= `MRWD_EXC_FUNC; // see R14
						tx_len_q <= 6'd6;
						st_q <= ST_REPLY;
					end
				end
				ST_COMMIT: begin
					// One register per cycle, ascending (see R8)
					if (i_wr_chk.reject) begin
						exc_q <= `MRWD_EXC_DATA; // Earlier commits stay (see R9)
						st_q <= ST_REPLY;
					end else if (buf_q[1] == `MRWD_FC_WRITE_ONE || {11'h000, cnt_q} + 16'h1 == num_w) begin
						st_q <= ST_REPLY;
					end else begin
						cnt_q <= cnt_q + 5'h01;
					end
				end
				ST_REPLY: begin
					// Last byte before CRC taken
					if (i_tx_ready && tx_idx_q == (exc_q != 8'h00 ? 6'd2 : tx_len_q - 6'd1)) begin
						st_q <= ST_CRC_LO;
					end
				end
				ST_CRC_LO: begin
					if (i_tx_ready) begin
						st_q <= ST_CRC_HI;
					end
				end
				ST_CRC_HI: begin
					if (i_tx_ready) begin
						st_q <= ST_RX;
					end
				end
				default: begin
					st_q <= ST_RX;
				end
			endcase
		end
	end

	// ************************************************************
	// Register commit port
	// ************************************************************
	// Address and value; address parity gives half (see R15)
	always_comb begin
		o_wr_valid = (st_q == ST_COMMIT); // see R1, R8
		o_wr.addr = base_w + {11'h000, cnt_q};
		if (buf_q[1] == `MRWD_FC_WRITE_ONE) begin
			o_wr.data = num_w;
		end else begin
			o_wr.data = {buf_q[7 + 2 * cnt_q], buf_q[8 + 2 * cnt_q]};
		end
		o_wr_half_lo = o_wr.addr[0]; // see R15
	end

	// ************************************************************
	// Reply stream
	// ************************************************************
	logic [7:0] byte_w; // Current reply byte before CRC
	always_comb begin
		if (exc_q != 8'h00 && tx_idx_q == 6'd1) begin
			byte_w = buf_q[1] | `MRWD_EXC_FLAG; // see R16
		end else if (exc_q != 8'h00 && tx_idx_q == 6'd2) begin
			byte_w = exc_q; // see R16
		end else begin
			byte_w = buf_q[tx_idx_q]; // see R1, R3, R6
		end
	end

	// Index and CRC of outgoing bytes
	always_ff @(posedge i_core_clk) begin
		if (!i_nrst) begin
			tx_idx_q <= 6'h00;
			tcrc_q <= `MRWD_CRC_INIT;
		end else if (st_q == ST_REPLY && i_tx_ready) begin
			tx_idx_q <= tx_idx_q + 6'h01;
			tcrc_q <= crc_step(tcrc_q, byte_w);
		end else if (st_q == ST_RX) begin
			tx_idx_q <= 6'h00;
			tcrc_q <= `MRWD_CRC_INIT;
		end
	end

	// Registered data toward the line, CRC low then high (see R11)
	always_ff @(posedge i_core_clk) begin
		if (!i_nrst) begin
			o_tx_data <= 8'h00;
			o_tx_last <= 1'b0;
		end else if (st_q == ST_REPLY && !i_tx_ready) begin
			o_tx_data <= byte_w;
			o_tx_last <= 1'b0;
		end else if (st_q == ST_CRC_LO && !i_tx_ready) begin
			o_tx_data <= tcrc_q[7:0];
			o_tx_last <= 1'b0;
		end else if (st_q == ST_CRC_HI && !i_tx_ready) begin
			o_tx_data <= tcrc_q[15:8];
			o_tx_last <= 1'b1;
		end else begin
			o_tx_data <= 8'h00;
			o_tx_last <= 1'b0;
		end
	end

	// Handshake follows state; data valid one cycle behind ready hold
	assign o_tx_valid = 1'b0 | ((st_q == ST_REPLY || st_q == ST_CRC_LO || st_q == ST_CRC_HI) && !i_tx_ready);
endmodule // mrwd_slave

// file: mrwd_slave_properties.sv
// Purpose: Port checks for mrwd_slave
// Assumes: One clock, sync active-low reset
// Notes: Bound after the module
`timescale 1ns/1ps
module mrwd_slave_properties (
	input wire logic i_core_clk,
	input wire logic i_nrst,
	input wire logic i_rx_valid,
	input wire logic i_rx_last,
	input wire logic o_wr_valid,
	input wire mrwd_pkg::mrwd_wr_t o_wr,
	input wire logic o_wr_half_lo,
	input wire mrwd_pkg::mrwd_chk_t i_wr_chk,
	input wire logic o_tx_valid,
	input wire logic [7:0] o_tx_data,
	input wire logic o_tx_last,
	input wire logic i_tx_ready
);
	logic [4:0] run_q; // Commits in a row
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_nrst);
	// Count back-to-back commits
	always_ff @(posedge i_core_clk) begin
		run_q <= (i_nrst && o_wr_valid) ? run_q + 5'h01 : 5'h00;
	end
	// Byte loaded while shown, then still shown or acked
	sequence s_held; o_tx_valid [*2] ##1 (o_tx_valid || i_tx_ready); endsequence
	// Last reply byte taken; valid drops while acked
	sequence s_end; i_tx_ready && o_tx_last; endsequence
	property p_half; o_wr_valid |-> o_wr_half_lo == o_wr.addr[0]; endproperty
	a_half: assert property (p_half) else $error("half flag");
	property p_asc; o_wr_valid && $past(o_wr_valid) |-> o_wr.addr == $past(o_wr.addr) + 16'h0001; endproperty
	a_asc: assert property (p_asc) else $error("order");
	property p_start; $rose(o_wr_valid) |-> $past(i_rx_valid, 2) && $past(i_rx_last, 2); endproperty
	a_start: assert property (p_start) else $error("commit time");
	property p_stop; o_wr_valid && i_wr_chk.reject |=> !o_wr_valid [*3]; endproperty
	a_stop: assert property (p_stop) else $error("after reject");
	property p_sep; o_tx_valid |-> !o_wr_valid; endproperty
	a_sep: assert property (p_sep) else $error("overlap");
	property p_max; o_wr_valid |-> run_q < 5'h10; endproperty
	a_max: assert property (p_max) else $error("too many");
	property p_hold; s_held |-> $stable(o_tx_data) && $stable(o_tx_last); endproperty
	a_hold: assert property (p_hold) else $error("byte moved");
	property p_quiet; s_end |=> !o_tx_valid [*4]; endproperty
	a_quiet: assert property (p_quiet) else $error("extra reply");
endmodule // mrwd_slave_properties
bind mrwd_slave mrwd_slave_properties u_mrwd_slave_properties (.i_core_clk, .i_nrst, .i_rx_valid,
	.i_rx_last, .o_wr_valid, .o_wr, .o_wr_half_lo, .i_wr_chk, .o_tx_valid, .o_tx_data, .o_tx_last, .i_tx_ready);

// file: mrwd_slave_tb.sv
// Purpose: Self-checking bench for mrwd_slave
// Assumes: Host model acks replies, refuses one value
// Notes: Seeded random frames plus corner cases
`timescale 1ns/1ps
`include "mrwd_params.svh"
module mrwd_slave_tb;
	localparam logic [7:0] own_adr = 8'h11; // Our slave address
	localparam logic [15:0] bad_val = 16'hDEAD; // Refused value
	logic clk = 1'b0;
	logic nrst = 1'b0;
	logic rx_v = 1'b0;
	logic rx_l = 1'b0;
	logic [7:0] rx_d = 8'h00;
	logic slow = 1'b0; // Late acks
	logic bad = 1'b0; // Corrupt check field
	logic wr_v, wr_lo, tx_v, tx_l, tx_r;
	logic [7:0] tx_d;
	mrwd_pkg::mrwd_wr_t wr;
	mrwd_pkg::mrwd_chk_t wchk;
	int bad_count = 0;
	int tests_run = 0;
	int cyc = 0;
	int nl = 0; // Last-flagged bytes seen
	int n;
	logic [7:0] f[$], e[$], rq[$]; // Frame, reply due, reply seen
	logic [31:0] w[$], wq[$]; // Commits due, seen
	mrwd_slave u_mrwd_slave (.i_core_clk(clk), .i_nrst(nrst), .i_own_addr(own_adr), .i_rx_valid(rx_v),
		.i_rx_data(rx_d), .i_rx_last(rx_l), .o_wr_valid(wr_v), .o_wr(wr), .o_wr_half_lo(wr_lo),
		.i_wr_chk(wchk), .o_tx_valid(tx_v), .o_tx_data(tx_d), .o_tx_last(tx_l), .i_tx_ready(tx_r));
	mrwd_host_model #(.bad_val(bad_val)) u_mrwd_host_model (.i_core_clk(clk), .i_nrst(nrst),
		.i_slow(slow), .i_wr_valid(wr_v), .i_wr(wr), .i_tx_valid(tx_v), .o_wr_chk(wchk), .o_tx_ready(tx_r));
	initial forever #5 clk = ~clk;
	// Record reply bytes and commits, cut hangs
	always @(posedge clk) begin
		cyc++;
		if (tx_r) rq.push_back(tx_d);
		if (tx_r && tx_l) nl++;
		if (wr_v) wq.push_back(wr);
		if (wr_v) chk(32'(wr_lo), 32'(wr.addr[0]));
		if (cyc == 40000) begin
			bad_count++;
			finish_test();
		end
	end
	function automatic logic [15:0] crc(input logic [7:0] b[$]);
		logic [15:0] c = `MRWD_CRC_INIT;
		foreach (b[i]) begin
			c ^= {8'h00, b[i]};
			repeat (8) c = c[0] ? (c >> 1) ^ `MRWD_CRC_POLY : c >> 1;
		end
		return c;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic finish_test();
		if (bad_count == 0 && tests_run > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic exc(input logic [7:0] fc, input logic [7:0] code);
		e = {own_adr, fc | `MRWD_EXC_FLAG, code};
	endtask
	task automatic one(input logic [15:0] ad, input logic [15:0] dv);
		f = {own_adr, `MRWD_FC_WRITE_ONE, ad[15:8], ad[7:0], dv[15:8], dv[7:0]};
		e = f;
		w.push_back({ad, dv});
	endtask
	task automatic mk(input logic [15:0] st, input logic [15:0] cnt, input logic [7:0] bc, input int k);
		logic [15:0] v;
		f = {own_adr, `MRWD_FC_WRITE_MANY, st[15:8], st[7:0], cnt[15:8], cnt[7:0], bc};
		e = f[0:5];
		for (int j = 0; j < k; j++) begin
			v = 16'($urandom) & 16'h7FFF;
			f.push_back(v[15:8]);
			f.push_back(v[7:0]);
			w.push_back({st + 16'(j), v});
		end
	endtask
	// Send a frame, then compare reply and commits
	task automatic go();
		logic [15:0] c = crc(f) ^ {15'h0000, bad};
		f.push_back(c[7:0]);
		f.push_back(c[15:8]);
		c = crc(e);
		if (e.size() != 0) e = {e, c[7:0], c[15:8]};
		foreach (f[i]) begin
			@(posedge clk);
			#1;
			rx_v = 1'b1;
			rx_d = f[i];
			rx_l = (i == f.size() - 1);
		end
		@(posedge clk);
		#1;
		rx_v = 1'b0;
		rx_l = 1'b0;
		for (int k = 0; k < 400 && rq.size() < e.size(); k++) @(posedge clk);
		repeat (20) @(posedge clk);
		#1;
		chk(rq.size(), e.size());
		chk(nl, 32'(e.size() != 0));
		nl = 0;
		foreach (e[i]) chk(rq[i], e[i]);
		chk(wq.size(), w.size());
		foreach (w[i]) chk(wq[i], w[i]);
		f.delete();
		e.delete();
		w.delete();
		rq.delete();
		wq.delete();
		slow = 1'($urandom);
	endtask
	task automatic ex3(input logic [15:0] cnt, input logic [7:0] bc, input int k);
		mk(16'h0100, cnt, bc, k);
		w.delete();
		exc(`MRWD_FC_WRITE_MANY, `MRWD_EXC_DATA);
		go();
	endtask
	initial begin
		void'($urandom(32'hCDD9));
		repeat (16) @(posedge clk);
		#1;
		nrst = 1'b1;
		repeat (4) begin
			one(16'($urandom_range(16'h1FFF, 0)), 16'($urandom));
			go();
		end
		for (n = 0; n < 5; n++) begin
			f = {own_adr, `MRWD_FC_DIAG, 8'h00, 8'(n / 4), 8'($urandom), 8'($urandom)};
			e = f;
			if (f[3] != 8'h00) exc(`MRWD_FC_DIAG, `MRWD_EXC_FUNC);
			go();
		end
		f = {own_adr, 8'h03, 8'h00, 8'h01, 8'h00, 8'h01};
		exc(8'h03, `MRWD_EXC_FUNC);
		go();
		for (n = 1; n <= 16; n *= 2) begin
			mk(16'($urandom_range(16'h1FEF, 0)) & 16'hFFFE, 16'(n), 8'(2 * n), n);
			go();
		end
		mk(16'h1FFE, 16'h0001, 8'h02, 1);
		go();
		mk(16'h1FFE, 16'h0002, 8'h04, 2);
		w.delete();
		exc(`MRWD_FC_WRITE_MANY, `MRWD_EXC_ADDR);
		go();
		one(16'h2000, 16'h1234);
		w.delete();
		exc(`MRWD_FC_WRITE_ONE, `MRWD_EXC_ADDR);
		go();
		ex3(16'h0000, 8'h00, 0);
		ex3(16'h0002, 8'h02, 1);
		ex3(16'h0011, 8'h22, 0);
		mk(16'h0400, 16'h0004, 8'h08, 4);
		f[11] = bad_val[15:8];
		f[12] = bad_val[7:0];
		w[2] = {16'h0402, bad_val};
		w.pop_back();
		exc(`MRWD_FC_WRITE_MANY, `MRWD_EXC_DATA);
		go();
		one(16'h0010, 16'h5555);
		bad = 1'b1;
		e.delete();
		w.delete();
		go();
		bad = 1'b0;
		one(16'h0010, 16'h5555);
		f[0] = own_adr ^ 8'h01;
		e.delete();
		w.delete();
		go();
		finish_test();
	end
endmodule // mrwd_slave_tb
